// *** src/mbd_decode.sv ***
/*
  Address decode and inhibit logic of a 32 KB socketed memory board.
  Assumes a bus master driving multiplexed address, strobes and two
  timing pulses; straps are static and sampled through synchronisers.
*/
// Behaviour
// - both bank inhibits kill whole top 4 KB
// - one-of-four decoder picks one 1 KB hole
// - hole confined to strap-chosen 2 KB bank
// - hole works with bank inhibits inactive
// - each 8 KB block independently ROM or RAM
// - ROM and RAM straps exclusive per block
// - inhibits only in top 4 KB of half
// - default hole lower 1 KB, strap moves up
// - latch high address on latch pulse fall
// - half chosen by latched bit 7 vs strap
// - buffers off unless selected; read drives bus
// - memory output enable gated by gate pulse
`timescale 1ns/1ps
`default_nettype none
module mbd_decode import mbd_pkg::*; (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // backplane bus
  input wire logic [7:0] addr_i,
  input wire logic address_latch_pulse_i,
  input wire logic output_gate_pulse_i,
  input wire logic mem_read_n_i,
  input wire logic mem_write_n_i,
  // straps
  input wire logic half_select_straps_i,
  input wire logic [1:0] bank_inhibit_straps_i,
  input wire logic [3:0] rom_select_straps_i,
  input wire logic [3:0] ram_select_straps_i,
  input wire logic hole_enable_i,
  input wire logic hole_bank_upper_i,
  input wire logic hole_seg_upper_i,
  // socket and buffer controls
  output logic [15:0] sock_sel_o,
  output logic [3:0] blk_write_o,
  output logic mem_oe_o,
  output logic board_select_o,
  output logic buf_to_bus_o,
  output logic buf_to_mem_o,
  output logic strap_fault_o
);
  // all assertions below run on the core clock, off during reset
  default clocking dflt_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  localparam int NSYNC = 16;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  logic [7:0] a_s;
  logic alp_s, ogp_s, rd_n_s, wr_n_s, half_s, en_s, bank_s, seg_s;
  logic rd_on_s, wr_on_s;
  logic [1:0] binh_s;
  logic [3:0] rom_s, ram_s, ram_n_s;

  // strobes and ram straps enter inverted, so the zero reset of the
  // flops reads as idle bus and valid straps: no phantom read and no
  // strap fault in the first cycles after reset
  assign raw = {addr_i, address_latch_pulse_i, output_gate_pulse_i,
                ~mem_read_n_i, ~mem_write_n_i, half_select_straps_i,
                hole_enable_i, hole_bank_upper_i, hole_seg_upper_i};
  assign {a_s, alp_s, ogp_s, rd_on_s, wr_on_s, half_s, en_s, bank_s,
          seg_s} = syn;
  assign rd_n_s = ~rd_on_s;
  assign wr_n_s = ~wr_on_s;
  assign ram_s = ~ram_n_s;

  // all pins pass two flops before use
  mbd_sync #(.W(NSYNC)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(raw),
    .q_o(syn)
  );
  mbd_sync #(.W(10)) u_sync_s (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({bank_inhibit_straps_i, rom_select_straps_i,
          ~ram_select_straps_i}),
    .q_o({binh_s, rom_s, ram_n_s})
  );

  // address latch state
  logic [7:0] hi_addr_r, hi_addr_nxt;
  logic alp_d_r, alp_d_nxt;

  // trailing edge of latch pulse captures high byte
  always_comb begin
    alp_d_nxt = alp_s;
    hi_addr_nxt = hi_addr_r;
    if (alp_d_r && !alp_s) begin
      hi_addr_nxt = a_s;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_addr_r <= ADDR_RST;
      alp_d_r <= 1'b0;
    end else begin
      hi_addr_r <= hi_addr_nxt;
      alp_d_r <= alp_d_nxt;
    end
  end

  // decode of the held address
  logic half_ok, in_top, in_bank, hole_hit, inhibit, cycle, sel_any;
  logic [1:0] blk;
  logic [1:0] sock;
  logic [3:0] ok_blk;
  logic [15:0] sel_nxt, sel_r;
  logic [3:0] wr_nxt, wr_r;
  logic oe_nxt, oe_r, bsel_nxt, bsel_r, tb_nxt, tb_r, tm_nxt, tm_r;
  logic flt_nxt, flt_r;

  always_comb begin
    blk = hi_addr_r[BLK_HI:BLK_LO];
    sock = hi_addr_r[SOCK_HI:SOCK_LO];
    half_ok = (hi_addr_r[HALF_BIT] == half_s);
    // holes only ever in top 4 KB of the half
    in_top = (blk == TOP_BLOCK) && sock[1];
    // bank inhibit: bit0 lower bank, bit1 upper bank
    inhibit = in_top && binh_s[sock[0]];
    // 1-of-4 hole decoder over {bank, segment}
    in_bank = (sock[0] == bank_s);
    hole_hit = en_s && in_top && in_bank
               && (hi_addr_r[SEG_BIT] == seg_s);
    // a straps pair that is both or neither selects nothing
    ok_blk = rom_s ^ ram_s;
    cycle = !rd_n_s || !wr_n_s;
    sel_any = cycle && half_ok && !inhibit && !hole_hit && ok_blk[blk];
    sel_nxt = SEL_RST;
    wr_nxt = WR_RST;
    if (sel_any) begin
      sel_nxt[{blk, sock}] = 1'b1;
    end
    // rom blocks ignore write strobes
    for (int i = 0; i < NUM_BLK; i++) begin
      wr_nxt[i] = sel_any && (blk == i[1:0]) && !wr_n_s
                  && ram_s[i] && !rom_s[i];
    end
    // output enable only in the gate pulse window
    oe_nxt = sel_any && !rd_n_s && ogp_s;
    bsel_nxt = sel_any;
    tb_nxt = sel_any && !rd_n_s;
    tm_nxt = sel_any && rd_n_s;
    flt_nxt = |(~ok_blk);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_r <= SEL_RST;
      wr_r <= WR_RST;
      oe_r <= 1'b0;
      bsel_r <= 1'b0;
      tb_r <= 1'b0;
      tm_r <= 1'b0;
      flt_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      wr_r <= wr_nxt;
      oe_r <= oe_nxt;
      bsel_r <= bsel_nxt;
      tb_r <= tb_nxt;
      tm_r <= tm_nxt;
      flt_r <= flt_nxt;
    end
  end

  assign sock_sel_o = sel_r;
  assign blk_write_o = wr_r;
  assign mem_oe_o = oe_r;
  assign board_select_o = bsel_r;
  assign buf_to_bus_o = tb_r;
  assign buf_to_mem_o = tm_r;
  assign strap_fault_o = flt_r;

  // checks; clock and reset come from the defaults at the top
  sequence s_latch_fall;
    alp_d_r && !alp_s;
  endsequence

  // latched high byte: taken on the fall, held otherwise
  a_latch_take: assert property (
    s_latch_fall |=> hi_addr_r == $past(a_s))
    else $error("high byte not taken on latch fall");
  a_latch_hold: assert property (
    !(alp_d_r && !alp_s) |=> $stable(hi_addr_r))
    else $error("address latch moved without trailing edge");

  // socket selects
  a_sel_onehot: assert property (
    $onehot0(sock_sel_o))
    else $error("more than one socket select");
  a_half_match: assert property (
    board_select_o |-> $past(half_ok))
    else $error("select in wrong half");
  a_strap_excl: assert property (
    !ok_blk[blk] |=> sock_sel_o == '0)
    else $error("select with conflicting straps");

  // inhibits and holes
  a_top_inhibit: assert property (
    (in_top && binh_s == 2'h3) |=> sock_sel_o == '0)
    else $error("select inside fully inhibited range");
  a_hole_quiet: assert property (
    hole_hit |=> !board_select_o)
    else $error("select inside hole");
  // the bank that is not chosen must keep answering
  a_hole_bank: assert property (
    (en_s && in_top && !in_bank && !inhibit && cycle && half_ok
    && ok_blk[blk]) |=> board_select_o)
    else $error("hole outside chosen bank");
  a_hole_alone: assert property (
    (en_s && binh_s == 2'h0 && in_top && in_bank
    && hi_addr_r[SEG_BIT] == seg_s) |=> !board_select_o)
    else $error("hole missing without bank inhibit");
  // below the top 4 KB a valid access is never refused
  a_top_only: assert property (
    (!in_top && cycle && half_ok && ok_blk[blk]) |=> board_select_o)
    else $error("inhibit outside top region");

  // write strobes and buffers
  a_rom_nowrite: assert property (
    (blk_write_o & $past(rom_s)) == 4'h0)
    else $error("write reached rom block");
  a_buf_dir: assert property (
    (buf_to_bus_o || buf_to_mem_o) |-> board_select_o
    && !(buf_to_bus_o && buf_to_mem_o))
    else $error("buffer enabled without select");
  a_buf_way: assert property (
    sel_any |=> buf_to_bus_o != $past(rd_n_s))
    else $error("buffer direction disagrees with read strobe");
  a_oe_gate: assert property (
    mem_oe_o |-> $past(ogp_s))
    else $error("output enable outside gate pulse");
endmodule
`default_nettype wire

// *** src/mbd_pkg.sv ***
/*
  Constants for the memory board address decode block.
  Assumes a single core clock at 125 MHz; all straps are static levels.
*/
package mbd_pkg;
  // latched high address byte fields
  localparam int HALF_BIT = 7;
  localparam int BLK_HI = 6;
  localparam int BLK_LO = 5;
  localparam int SOCK_HI = 4;
  localparam int SOCK_LO = 3;
  localparam int BANK_BIT = 3;
  localparam int SEG_BIT = 2;
  // top 4 KB lives in 8 KB block 3, sockets 2 and 3
  localparam logic [1:0] TOP_BLOCK = 2'h3;
  localparam int NUM_SOCK = 16;
  localparam int NUM_BLK = 4;
  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [3:0] WR_RST = 4'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;
  // pin synchroniser depth in cycles
  localparam int SYNC_CYCLES = 2;
endpackage

// *** src/mbd_sync.sv ***
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes inputs are asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module mbd_sync import mbd_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // first stage is read only by the second
  always_comb begin
    meta_nxt = d_i;
    q_nxt = meta_r;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule
`default_nettype wire

// *** dv/mbd_bus_master.sv ***
/*
  Bus master model: multiplexed address, timing pulses and strobes.
  Assumes the decode block samples every pin through two flops.
*/
`timescale 1ns/1ps
`default_nettype none
module mbd_bus_master (
  // clock
  input wire logic core_clk_i,
  // bus pins
  output logic [7:0] addr_o,
  output logic latch_o,
  output logic gate_o,
  output logic rd_n_o,
  output logic wr_n_o
);
  // idle bus at time zero
  initial begin
    addr_o = 8'h00;
    latch_o = 1'b0;
    gate_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
  end
  // high byte held past the sync delay, then low byte and strobe
  task automatic start(input logic [7:0] hi, input logic wr, input logic g);
    @(posedge core_clk_i);
    #1 addr_o = hi;
    latch_o = 1'b1;
    @(posedge core_clk_i);
    #1 latch_o = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1 addr_o = ~hi; // low byte time, not the latched value
    rd_n_o = wr;
    wr_n_o = ~wr;
    gate_o = g;
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask
  // release strobes; outputs settle three edges later
  task automatic stop();
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    gate_o = 1'b0;
    addr_o = ~addr_o;
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// *** dv/memory_board_address_decode_tb.sv ***
/*
  Self-checking bench for the memory board address decode block.
  Assumes the bus master model drives every bus pin.
*/
`timescale 1ns/1ps
`default_nettype none
module memory_board_address_decode_tb import mbd_pkg::*; ;
  logic clk = 1'b0, rst_n = 1'b0, half = 1'b0, hen = 1'b0;
  logic hbu = 1'b0, hsu = 1'b0, lp, gp, rd_n, wr_n;
  logic oe, bsel, tobus, tomem, flt;
  logic [1:0] bi = 2'h0;
  logic [3:0] rom = 4'h0, ram = 4'hF, bw;
  logic [7:0] addr;
  logic [15:0] sel;
  int n_mismatch = 0, checked = 0, cyc = 0;
  mbd_bus_master bm_u (.core_clk_i(clk), .addr_o(addr), .latch_o(lp),
    .gate_o(gp), .rd_n_o(rd_n), .wr_n_o(wr_n));
  mbd_decode dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .address_latch_pulse_i(lp), .output_gate_pulse_i(gp),
    .mem_read_n_i(rd_n), .mem_write_n_i(wr_n), .half_select_straps_i(half),
    .bank_inhibit_straps_i(bi), .rom_select_straps_i(rom),
    .ram_select_straps_i(ram), .hole_enable_i(hen), .hole_bank_upper_i(hbu),
    .hole_seg_upper_i(hsu), .sock_sel_o(sel), .blk_write_o(bw),
    .mem_oe_o(oe), .board_select_o(bsel), .buf_to_bus_o(tobus),
    .buf_to_mem_o(tomem), .strap_fault_o(flt));
  // clock and hang guard; ceiling well above the run length
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected select from straps; zero when refused
  function automatic logic [15:0] exp_sel(input logic [7:0] a);
    logic top;
    top = (a[6:5] == TOP_BLOCK) && a[4];
    if (a[7] != half || rom[a[6:5]] == ram[a[6:5]]) return 16'h0000;
    if (top && bi[a[3]]) return 16'h0000;
    if (top && hen && hbu == a[3] && hsu == a[2]) return 16'h0000;
    return 16'h0001 << a[6:3];
  endfunction
  // one whole access, then release must clear every output but the strap fault
  task automatic acc(input logic [7:0] a, input logic wr, input logic g);
    logic [15:0] e;
    logic [15:0] w;
    e = exp_sel(a);
    w = (e != 16'h0000 && ram[a[6:5]]) ? 16'h0001 << a[6:5] : 16'h0000;
    bm_u.start(a, wr, g);
    if (wr) begin
      chk({12'h000, bw}, w);
      chk(sel, e);
      chk({oe, bsel, tobus, tomem}, {1'b0, e != 16'h0000, 1'b0,
        e != 16'h0000});
    end else begin
      chk(sel, e);
      chk({oe, bsel, tobus, tomem}, {e != 16'h0000 && g, {2{e != 16'h0000}},
        1'b0});
    end
    bm_u.stop();
    chk(sel | {bw, oe, bsel, tobus, tomem, 8'h00}, 16'h0000);
  endtask
  task automatic t_map();
    for (int h = 0; h < 2; h++) begin
      half = h[0];
      for (int i = 0; i < 32; i++) acc(8'(i << 3), 1'b0, 1'b1);
    end
    half = 1'b0;
    $display("t_map done");
  endtask
  task automatic t_bank();
    for (int b = 1; b < 4; b++) begin
      bi = b[1:0];
      acc(8'h70, 1'b0, 1'b1);
      acc(8'h78, 1'b0, 1'b1);
      acc(8'h68, 1'b0, 1'b1);
    end
    bi = 2'h0;
    $display("t_bank done");
  endtask
  task automatic t_hole();
    hen = 1'b1;
    for (int k = 0; k < 4; k++) begin
      {hbu, hsu} = k[1:0];
      for (int j = 0; j < 4; j++) acc(8'(8'h70 | (j << 2)), 1'b0, 1'b1);
      acc(8'h34, 1'b0, 1'b1);
    end
    hen = 1'b0;
    $display("t_hole done");
  endtask
  task automatic t_mix();
    rom = 4'h5;
    ram = 4'hA;
    for (int b = 0; b < 4; b++) begin
      acc(8'(b << 5), 1'b1, 1'b1);
      acc(8'(b << 5), 1'b0, 1'b0);
    end
    rom = 4'h3;
    ram = 4'hE;
    repeat (4) @(posedge clk);
    #1 chk({15'h0000, flt}, 16'h0001);
    acc(8'h20, 1'b0, 1'b1);
    acc(8'h08, 1'b1, 1'b1);
    rom = 4'h0;
    ram = 4'hF;
    repeat (4) @(posedge clk);
    #1 chk({15'h0000, flt}, 16'h0000);
    $display("t_mix done");
  endtask
  // reset for four cycles, then wait out the sync start-up
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    // every output must be quiet from the first edge after release
    @(posedge clk);
    #1 chk(sel | {bw, oe, bsel, tobus, tomem, flt, 7'h00}, 16'h0000);
    repeat (2) @(posedge clk);
    t_map();
    t_bank();
    t_hole();
    t_mix();
    summarize();
  end
endmodule
`default_nettype wire
